// ---- core/mdc_top.sv ----
// What this block does
// - With the channel-count bit clear, only the U phase PWM feeds the outputs.
// - With the channel-count bit set, the U, V and W PWMs each drive their own switch pair.
// - The deadtime enable bit turns the deadtime generator off or on, complementing the adjacent switch.
// - The six-bit deadtime setting picks the deadtime length and its step size.
// - Deadtime enable is write-once while channel-count is set and freely writable while it is clear.
// - After the first write to the config register its write-once bits ignore writes until reset.
// - The mode bits only drive the outputs while peripheral clock enable and output enable are set.
// - Three-pair mode with deadtime and chopper off gives exactly complementary high and low sides on pairs with both state bits set.
// - Channel-count clear, direct access and deadtime off allow PWM or levels, never complements.
// - Channel-count clear with deadtime on pairs the outputs and drives complementary PWM.
// - In paired mode an output-select bit picks the PWM side and a chopper may modulate it.
// - Output mode follows the state bits, output-enable bits and the two output-select bits.
// - In direct access, a phase-state write loads the active state at once, not at commutation.
`timescale 1ns/1ns
module mdc_top
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // phase pwm and commutation from the counter logic
  input wire logic PWM_U,
  input wire logic PWM_V,
  input wire logic PWM_W,
  input wire logic COMMUTATE,
  // motor output channels
  output logic [5:0] MCO
);

  mdc_bus_type state_reg, state_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic resp_reg;
  logic pcn_reg, pcn_next;
  logic dte_reg, dte_next;
  logic [5:0] dtg_reg, dtg_next;
  logic lock_reg, lock_next;
  logic [9:0] ctrl_reg, ctrl_next;
  logic [5:0] preload_reg, preload_next;
  logic [5:0] active_reg, active_next;
  logic [5:0] outen_reg, outen_next;
  logic [5:0] mco_reg, mco_next;
  logic take, wr, wr_cfg, wr_phase;
  logic run, paired, dac, osl, osh;
  logic [1:0] che;
  logic [2:0] chf;
  logic carrier, chop_hi, chop_lo;
  logic [8:0] dt_len;
  logic [2:0] pwm_vec, dt_src, dt_hi, dt_lo;

  // control field views
  assign run = ctrl_reg[CTRL_CKE_BIT] && ctrl_reg[CTRL_MOE_BIT];
  assign dac = ctrl_reg[CTRL_DAC_BIT];
  assign osl = ctrl_reg[CTRL_OSL_BIT];
  assign osh = ctrl_reg[CTRL_OSH_BIT];
  assign che = ctrl_reg[CTRL_CHE_LSB +: 2];
  assign chf = ctrl_reg[CTRL_CHF_LSB +: 3];
  assign paired = !pcn_reg && dte_reg;
  assign dt_len = dt_cycles(dtg_reg);

  // bus strobes
  assign take = HSEL && HTRANS[1] && HREADY;
  assign wr = (state_reg == BUS_WRITE);
  assign wr_cfg = wr && (addr_reg == ADDR_CFG);
  assign wr_phase = wr && (addr_reg == ADDR_PHASE);

  // bus phase tracking, reads get one wait state
  always_comb
  begin
    state_next = BUS_IDLE;
    addr_next = addr_reg;
    rdata_next = rdata_reg;
    ready_next = 1'b1;
    if (state_reg == BUS_READ)
    begin
      if (addr_reg == ADDR_CFG)
      begin
        rdata_next = {24'h000000, pcn_reg, dte_reg, dtg_reg};
      end
      else if (addr_reg == ADDR_CTRL)
      begin
        rdata_next = {22'h000000, ctrl_reg};
      end
      else if (addr_reg == ADDR_PHASE)
      begin
        rdata_next = {26'h0000000, active_reg};
      end
      else if (addr_reg == ADDR_OUTEN)
      begin
        rdata_next = {26'h0000000, outen_reg};
      end
      else if (addr_reg == ADDR_STATUS)
      begin
        rdata_next = {19'h00000, lock_reg, mco_reg, active_reg};
      end
      else
      begin
        rdata_next = 32'h00000000;
      end
    end
    if (take)
    begin
      addr_next = HADDR[7:0];
      state_next = HWRITE ? BUS_WRITE : BUS_READ;
      ready_next = HWRITE;
    end
  end

  // bus registers
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= BUS_IDLE;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b1;
      resp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      resp_reg <= 1'b0;
    end
  end

  // config, control and phase-state registers
  always_comb
  begin
    pcn_next = pcn_reg;
    dte_next = dte_reg;
    dtg_next = dtg_reg;
    lock_next = lock_reg;
    ctrl_next = ctrl_reg;
    preload_next = preload_reg;
    active_next = active_reg;
    outen_next = outen_reg;
    if (wr_cfg)
    begin
      pcn_next = HWDATA[CFG_PCN_BIT];
      // clearing pcn first reopens the enable bit
      if (!(lock_reg && pcn_reg))
      begin
        dte_next = HWDATA[CFG_DTE_BIT];
      end
      if (!lock_reg)
      begin
        dtg_next = HWDATA[5:0];
      end
      lock_next = 1'b1;
    end
    if (wr && (addr_reg == ADDR_CTRL))
    begin
      ctrl_next = HWDATA[9:0];
    end
    if (wr && (addr_reg == ADDR_OUTEN))
    begin
      outen_next = HWDATA[5:0];
    end
    if (wr_phase)
    begin
      preload_next = HWDATA[5:0];
    end
    if (wr_phase && dac)
    begin
      active_next = HWDATA[5:0];
    end
    else if (COMMUTATE && !dac)
    begin
      active_next = preload_reg;
    end
  end

  // register file flops
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      pcn_reg <= CFG_RESET[CFG_PCN_BIT];
      dte_reg <= CFG_RESET[CFG_DTE_BIT];
      dtg_reg <= CFG_RESET[5:0];
      lock_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      preload_reg <= PHASE_RESET;
      active_reg <= PHASE_RESET;
      outen_reg <= OUTEN_RESET;
    end
    else
    begin
      pcn_reg <= pcn_next;
      dte_reg <= dte_next;
      dtg_reg <= dtg_next;
      lock_reg <= lock_next;
      ctrl_reg <= ctrl_next;
      preload_reg <= preload_next;
      active_reg <= active_next;
      outen_reg <= outen_next;
    end
  end

  // one deadtime generator per phase, all fed by U when single channel
  assign pwm_vec = {PWM_W, PWM_V, PWM_U};
  assign dt_src = pcn_reg ? pwm_vec : {3{PWM_U}};

  for (genvar g = 0; g < 3; g++)
  begin : g_dt
    mdc_deadtime u_dt (
      .clk(CLOCK),
      .nrst(NRST),
      .enable(dte_reg),
      .dt_len(dt_len),
      .pwm_in(dt_src[g]),
      .hi_out(dt_hi[g]),
      .lo_out(dt_lo[g])
    );
  end

  // chopper carrier
  mdc_chopper u_chop (
    .clk(CLOCK),
    .nrst(NRST),
    .freq(chf),
    .carrier(carrier)
  );

  assign chop_hi = !che[0] || carrier;
  assign chop_lo = !che[1] || carrier;

  // output channel manager
  always_comb
  begin
    mco_next = 6'h00;
    for (int i = 0; i < 3; i++)
    begin
      if (!run)
      begin
        mco_next[2*i] = 1'b0;
        mco_next[2*i+1] = 1'b0;
      end
      else if (pcn_reg)
      begin
        // three independent pairs
        mco_next[2*i] = active_reg[2*i] && dt_hi[i] && chop_hi;
        mco_next[2*i+1] = active_reg[2*i+1] && dt_lo[i] && chop_lo;
      end
      else if (paired)
      begin
        // pair follows U, side picked by output select
        if (active_reg[2*i] || active_reg[2*i+1])
        begin
          mco_next[2*i] = osl ? dt_lo[0] : (dt_hi[0] && chop_hi);
          mco_next[2*i+1] = osl ? (dt_hi[0] && chop_lo) : dt_lo[0];
        end
      end
      else
      begin
        // independent channels: level or U pwm, no complement
        mco_next[2*i] = active_reg[2*i] && (!outen_reg[2*i] || (PWM_U && chop_hi));
        mco_next[2*i+1] = active_reg[2*i+1] && (!outen_reg[2*i+1] || !osh || (PWM_U && chop_lo));
      end
    end
  end

  // output flops
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      mco_reg <= 6'h00;
    end
    else
    begin
      mco_reg <= mco_next;
    end
  end

  assign MCO = mco_reg;
  assign HRDATA = rdata_reg;
  assign HREADYOUT = ready_reg;
  assign HRESP = resp_reg;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_dtg_locked: assert property (wr_cfg && lock_reg |=> $stable(dtg_reg))
    else $error("deadtime setting changed while locked");
  a_dte_free_write: assert property (wr_cfg && !pcn_reg |=> dte_reg == $past(HWDATA[CFG_DTE_BIT]))
    else $error("enable bit not writable with pcn clear");
  a_dte_once_locked: assert property (wr_cfg && pcn_reg && lock_reg |=> $stable(dte_reg))
    else $error("enable bit rewritten in three-pair mode");
  a_outputs_off: assert property (!run |=> MCO == 6'h00)
    else $error("outputs active without clock and output enable");
  a_zero_deadtime: assert property (
    (run && pcn_reg && !dte_reg && che == 2'b00 && active_reg[1:0] == 2'b11) [*2] |=> MCO[1] != MCO[0])
    else $error("three-pair outputs not exact complements");
  a_direct_load: assert property (wr_phase && dac |=> active_reg == $past(HWDATA[5:0]))
    else $error("direct access write not loaded at once");
  a_commut_load: assert property (COMMUTATE && !dac |=> active_reg == $past(preload_reg))
    else $error("commutation did not load preload");
  a_pair_exclusive: assert property (run && paired |=> !(MCO[0] && MCO[1]))
    else $error("paired switches on together");
  a_u_only: assert property (
    run && !pcn_reg && !dte_reg && active_reg == 6'h3f && outen_reg == 6'h3f && osh && che == 2'b00
    |=> MCO == {6{$past(PWM_U)}})
    else $error("single-channel outputs not following U");

  c_three_pair: cover property (run && pcn_reg && dte_reg ##1 MCO[0]);
  c_paired: cover property (run && paired ##1 MCO[1]);
  c_direct: cover property (wr_phase && dac);
  c_locked_write: cover property (wr_cfg && lock_reg);

endmodule : mdc_top

// ---- core/mdc_pkg.sv ----
package mdc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PHASE = 8'h08;
  localparam logic [7:0] ADDR_OUTEN = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // deadtime_channel_config fields and reset value
  localparam int CFG_PCN_BIT = 7;
  localparam int CFG_DTE_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'hff;

  // control_reg_b fields
  localparam int CTRL_CKE_BIT = 0;
  localparam int CTRL_MOE_BIT = 1;
  localparam int CTRL_DAC_BIT = 2;
  localparam int CTRL_OSL_BIT = 3;
  localparam int CTRL_OSH_BIT = 4;
  localparam int CTRL_CHE_LSB = 5;
  localparam int CTRL_CHF_LSB = 7;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [5:0] PHASE_RESET = 6'h00;
  localparam logic [5:0] OUTEN_RESET = 6'h00;

  // deadtime steps in clock cycles: fine, medium, coarse ranges
  localparam int CLK_PERIOD_NS = 50;
  localparam int DT_FINE_SHIFT = 1;
  localparam int DT_MID_SHIFT = 2;
  localparam int DT_COARSE_SHIFT = 3;
  localparam logic [8:0] DT_MID_BASE = 9'h040;
  localparam logic [8:0] DT_COARSE_BASE = 9'h080;

  // bus slave phases
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} mdc_bus_type;

  // deadtime setting to length in cycles
  function automatic logic [8:0] dt_cycles(input logic [5:0] dtg);
    logic [8:0] r;
    r = 9'h000;
    if (!dtg[5])
    begin
      r = 9'(({3'h0, dtg} + 9'h001) << DT_FINE_SHIFT);
    end
    else if (!dtg[4])
    begin
      r = 9'(DT_MID_BASE + (({5'h00, dtg[3:0]} + 9'h001) << DT_MID_SHIFT));
    end
    else
    begin
      r = 9'(DT_COARSE_BASE + (({5'h00, dtg[3:0]} + 9'h001) << DT_COARSE_SHIFT));
    end
    return r;
  endfunction : dt_cycles

endpackage : mdc_pkg

// ---- core/mdc_deadtime.sv ----
`timescale 1ns/1ns
module mdc_deadtime
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic [8:0] dt_len,
  // pwm in, switch pair out
  input wire logic pwm_in,
  output logic hi_out,
  output logic lo_out
);

  logic pwm_d_reg, pwm_d_next;
  logic [8:0] cnt_reg, cnt_next;
  logic hi_reg, hi_next;
  logic lo_reg, lo_next;

  // both switches off for dt_len plus one cycles after each pwm edge
  always_comb
  begin
    pwm_d_next = pwm_in;
    cnt_next = 9'h000;
    hi_next = pwm_in;
    lo_next = !pwm_in;
    if (enable && (pwm_in != pwm_d_reg))
    begin
      cnt_next = dt_len;
      hi_next = 1'b0;
      lo_next = 1'b0;
    end
    else if (enable && (cnt_reg != 9'h000))
    begin
      cnt_next = cnt_reg - 9'h001;
      hi_next = 1'b0;
      lo_next = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_d_reg <= 1'b0;
      cnt_reg <= 9'h000;
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
    end
    else
    begin
      pwm_d_reg <= pwm_d_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end

  assign hi_out = hi_reg;
  assign lo_out = lo_reg;

  a_dt_gap: assert property (@(posedge clk) disable iff (!nrst)
    enable && (pwm_in != pwm_d_reg) |=> (!hi_reg && !lo_reg) [*2])
    else $error("deadtime gap missing after pwm edge");

endmodule : mdc_deadtime

// ---- core/mdc_chopper.sv ----
`timescale 1ns/1ns
module mdc_chopper
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // carrier frequency select and output
  input wire logic [2:0] freq,
  output logic carrier
);

  logic [7:0] cnt_reg, cnt_next;
  logic car_reg, car_next;

  // free-running divider, carrier is one of its bits
  always_comb
  begin
    cnt_next = cnt_reg + 8'h01;
    car_next = cnt_reg[freq];
  end

  // state registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 8'h00;
      car_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      car_reg <= car_next;
    end
  end

  assign carrier = car_reg;

endmodule : mdc_chopper

// ---- test/mdc_stage_model.sv ----
`timescale 1ns/1ns
module mdc_stage_model
(
  // gate drive from the motor outputs
  input wire logic [5:0] gate,
  // leg state and rail short flags
  output logic [2:0] leg_on,
  output logic [2:0] shoot
);
  // high switch pulls the phase node up; both on shorts the supply
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      leg_on[i] = gate[2 * i] & ~gate[2 * i + 1];
      shoot[i] = gate[2 * i] & gate[2 * i + 1];
    end
  end
endmodule : mdc_stage_model

// ---- test/motor_pwm_deadtime_config_test.sv ----
`timescale 1ns/1ns
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %0t %s", $time, m); end end
module motor_pwm_deadtime_config_test
  import mdc_pkg::*;
;
  logic clock, nrst, hsel, hwrite, pwm_u, pwm_v, pwm_w, commutate, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0] mco;
  logic [2:0] leg_on, shoot;
  int n_mismatch = 0;
  int cmp_count = 0;

  // block under test and power stage
  mdc_top i_dut (.CLOCK(clock), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .PWM_U(pwm_u), .PWM_V(pwm_v), .PWM_W(pwm_w), .COMMUTATE(commutate), .MCO(mco));
  mdc_stage_model i_stage (.gate(mco), .leg_on(leg_on), .shoot(shoot));

  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // ready as the slave saw it at each rising edge, bounded
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_mismatch++;
        end_sim();
      end
      @(posedge clock);
    end
  endtask : wait_rdy

  // one single word transfer, read data left in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0, "bus response")
  endtask : bus

  task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h00000000);
    `CHK(rd, e, m)
  endtask : rdchk

  task do_reset;
    @(posedge clock);
    nrst <= 1'b0;
    htrans <= 2'h0;
    pwm_u <= 1'b0;
    pwm_v <= 1'b0;
    pwm_w <= 1'b0;
    commutate <= 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
  endtask : do_reset

  task settle;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask : settle

  task drive_pwm(input logic u, input logic v, input logic w);
    @(posedge clock);
    pwm_u <= u;
    pwm_v <= v;
    pwm_w <= w;
    settle();
  endtask : drive_pwm

  // gap in cycles where both switches of a pair are off
  function automatic int dt_expect(input logic [5:0] g);
    if (!g[5])
    begin
      return (int'(g) + 1) * 2 + 1;
    end
    if (!g[4])
    begin
      return 64 + (int'(g[3:0]) + 1) * 4 + 1;
    end
    return 128 + (int'(g[3:0]) + 1) * 8 + 1;
  endfunction : dt_expect

  task s_reset_values;
    do_reset();
    rdchk(ADDR_CFG, 32'h000000ff, "config reset");
    `CHK(mco, 6'h00, "outputs after reset")
    bus(1'b1, 8'h20, 32'h000000ff);
    rdchk(8'h20, 32'h00000000, "unmapped read");
  endtask : s_reset_values

  task s_write_once;
    do_reset();
    bus(1'b1, ADDR_CFG, 32'h00000085);
    bus(1'b1, ADDR_CFG, 32'h000000c0);
    rdchk(ADDR_CFG, 32'h00000085, "locked bits changed");
    bus(1'b1, ADDR_CFG, 32'h00000045);
    rdchk(ADDR_CFG, 32'h00000005, "enable set with pcn");
    bus(1'b1, ADDR_CFG, 32'h00000045);
    rdchk(ADDR_CFG, 32'h00000045, "enable not free");
    bus(1'b1, ADDR_CFG, 32'h00000005);
    rdchk(ADDR_CFG, 32'h00000005, "enable not cleared");
  endtask : s_write_once

  task s_three_pair;
    do_reset();
    bus(1'b1, ADDR_CFG, 32'h00000085);
    bus(1'b1, ADDR_CTRL, 32'h00000007);
    bus(1'b1, ADDR_PHASE, 32'h0000003f);
    drive_pwm(1'b1, 1'b0, 1'b1);
    `CHK(mco, 6'h19, "exact complement")
    `CHK(shoot, 3'h0, "rail short")
    drive_pwm(1'b0, 1'b1, 1'b0);
    `CHK(mco, 6'h26, "phases not independent")
    bus(1'b1, ADDR_CTRL, 32'h00000005);
    settle();
    `CHK(mco, 6'h00, "output enable ignored")
  endtask : s_three_pair

  task s_deadtime;
    logic [5:0] tbl [4];
    int n;
    tbl = '{6'h00, 6'h1f, 6'h20, 6'h3f};
    foreach (tbl[k])
    begin
      do_reset();
      bus(1'b1, ADDR_CFG, {24'h000000, 2'h3, tbl[k]});
      bus(1'b1, ADDR_CTRL, 32'h00000007);
      bus(1'b1, ADDR_PHASE, 32'h00000003);
      repeat (300) @(posedge clock);
      @(negedge clock);
      `CHK(mco[1:0], 2'h2, "low side off")
      @(posedge clock);
      pwm_u <= 1'b1;
      n = 0;
      for (int c = 0; c < 600; c++)
      begin
        @(negedge clock);
        if (mco[1:0] === 2'h0)
        begin
          n++;
        end
      end
      `CHK(n, dt_expect(tbl[k]), "deadtime length")
      `CHK(mco[1:0], 2'h1, "high side off")
    end
  endtask : s_deadtime

  task s_paired;
    int n;
    do_reset();
    bus(1'b1, ADDR_CFG, 32'h00000040);
    bus(1'b1, ADDR_CTRL, 32'h00000007);
    bus(1'b1, ADDR_PHASE, 32'h00000003);
    drive_pwm(1'b1, 1'b0, 1'b0);
    `CHK(mco, 6'h01, "paired high side")
    // chopper on high side, carrier from divider bit 0
    bus(1'b1, ADDR_CTRL, 32'h00000027);
    rdchk(ADDR_CTRL, 32'h00000027, "control readback");
    settle();
    n = 0;
    for (int c = 0; c < 16; c++)
    begin
      @(negedge clock);
      if (mco[0] === 1'b1)
      begin
        n++;
      end
    end
    `CHK(n, 8, "chopper duty")
    `CHK(mco[1], 1'b0, "chopped low side")
    bus(1'b1, ADDR_CTRL, 32'h0000000f);
    settle();
    `CHK(mco, 6'h02, "output select swap")
    drive_pwm(1'b0, 1'b0, 1'b0);
    `CHK(mco, 6'h01, "paired complement")
  endtask : s_paired

  task s_single;
    do_reset();
    bus(1'b1, ADDR_CFG, 32'h00000000);
    bus(1'b1, ADDR_CTRL, 32'h00000007);
    bus(1'b1, ADDR_OUTEN, 32'h0000003f);
    bus(1'b1, ADDR_PHASE, 32'h0000003f);
    drive_pwm(1'b0, 1'b1, 1'b1);
    `CHK(mco, 6'h2a, "levels with pwm low")
    drive_pwm(1'b1, 1'b0, 1'b0);
    `CHK(mco, 6'h3f, "only u drives")
    bus(1'b1, ADDR_CTRL, 32'h00000017);
    drive_pwm(1'b0, 1'b0, 1'b0);
    `CHK(mco, 6'h00, "high select mode")
    bus(1'b1, ADDR_OUTEN, 32'h00000000);
    settle();
    `CHK(mco, 6'h3f, "state bits as levels")
  endtask : s_single

  task s_direct;
    do_reset();
    bus(1'b1, ADDR_CTRL, 32'h00000003);
    bus(1'b1, ADDR_PHASE, 32'h00000015);
    rdchk(ADDR_PHASE, 32'h00000000, "loaded early");
    @(posedge clock);
    commutate <= 1'b1;
    @(posedge clock);
    commutate <= 1'b0;
    rdchk(ADDR_PHASE, 32'h00000015, "commutation load");
    bus(1'b1, ADDR_CTRL, 32'h00000007);
    bus(1'b1, ADDR_PHASE, 32'h0000002a);
    rdchk(ADDR_PHASE, 32'h0000002a, "direct load");
    rdchk(ADDR_STATUS, 32'h00000aaa, "status view");
  endtask : s_direct

  // main sequence
  initial
  begin
    nrst = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    pwm_u = 1'b0;
    pwm_v = 1'b0;
    pwm_w = 1'b0;
    commutate = 1'b0;
    s_reset_values();
    s_write_once();
    s_three_pair();
    s_deadtime();
    s_paired();
    s_single();
    s_direct();
    end_sim();
  end
endmodule : motor_pwm_deadtime_config_test
